// [core/spimc_ctrl.sv]
// serial peripheral controller: transmit fifo, master engine, slave receiver
`timescale 1ns/1ps

// ------------------------------------------------------------------------
// transmit fifo
// ------------------------------------------------------------------------
module spimc_fifo #(
  parameter int WIDTH = 19,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic flush,
  // fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic [AW:0] cnt_d;
  logic ready_q;
  logic push;
  logic pop;

  assign push = in_valid && ready_q;
  assign pop = out_valid && out_ready;
  assign out_valid = cnt_q != '0;
  assign out_data = mem_q[rd_q];
  assign in_ready = ready_q;

  always_comb begin
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // ready is registered so the fill side never sees a combinational path
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      ready_q <= 1'b0;
    end else if (flush) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      ready_q <= 1'b1;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_d;
      ready_q <= cnt_d < FULL;
    end
  end
endmodule

// ------------------------------------------------------------------------
// controller top
// ------------------------------------------------------------------------
// Contract
// - odd divider not 1, polarity 1, phase 0: one extra clock pulse.
// - hold, divider 1, same slave after idle: tx-ready flag stays low.
// - last-transfer bit in fixed hold mode raises chip select at empty.
// - master serial clock may toggle before the first transfer.
// - fixed mode dma size follows chip select 0 bit count.
// - divider 1 with odd bit count 9..23 adds one clock pulse.
// - disable is ignored in slave mode; software resets instead.
// - disable during a transfer starts endless dummy transfers.
// - software reset keeps enable bit; re-enable sets no flags.
// - held select idle beyond both delays switches without select delay.
// - polarity 1 phase 0, slow select then divider-1 select: extra pulse.
// - all selects at divider 1 give no extra pulse from mixing.
module spimc_ctrl (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // commands, one-cycle pulses
  input wire logic cmd_enable,
  input wire logic cmd_disable,
  input wire logic cmd_soft_reset,
  // configuration
  input wire logic master_select_bit,
  input wire logic fixed_select_mode,
  input wire logic [1:0] fixed_select,
  input wire logic [7:0] between_cs_delay,
  input wire spimc_pkg::spimc_cs_cfg_s [spimc_pkg::NCS-1:0] cs_config_reg,
  // transmit stream
  input wire logic tx_valid,
  input wire spimc_pkg::spimc_tx_word_s tx_data_reg,
  output logic tx_ready,
  // receive stream
  output logic rx_valid,
  output logic [spimc_pkg::DATA_W-1:0] rx_data,
  // status
  output logic enable_state_bit,
  output logic tx_ready_flag,
  output logic transmit_empty_flag,
  output logic dma_size_half,
  // serial pins
  output logic serial_clock_out,
  output logic serial_clock_oe,
  output logic mosi_out,
  input wire logic miso_in,
  output logic [spimc_pkg::NCS-1:0] peripheral_cs_lines_n,
  input wire logic slave_clock_in,
  input wire logic slave_select_n_in,
  input wire logic slave_data_in
);
  spimc_pkg::spimc_state_e state_q;
  spimc_pkg::spimc_tx_word_s head;
  spimc_pkg::spimc_cs_cfg_s cfg_n;
  spimc_pkg::spimc_cs_cfg_s cfg_a;
  logic head_valid;
  logic pop;
  logic [1:0] cs_next;
  logic [1:0] cs_q;
  logic cs_on_q;
  logic [7:0] cnt_q;
  logic [5:0] edge_q;
  logic [5:0] edges_q;
  logic [15:0] sh_q;
  logic [15:0] rxs_q;
  logic last_q;
  logic dummy_q;
  logic [8:0] idle_q;
  logic prev_one_q;
  logic sck_q;
  logic mosi_q;
  logic en_q;
  logic flags_ok_q;
  logic suppress_q;
  logic m_done_q;
  logic [4:0] nb_n;
  logic [4:0] nb_a;
  logic all_one;
  logic extra;
  logic direct;
  logic idle_st;
  logic [5:0] data_edges;
  logic leading;
  logic change;
  logic flush;

  assign flush = cmd_soft_reset;
  assign idle_st = state_q == spimc_pkg::ST_IDLE ||
                   state_q == spimc_pkg::ST_HOLD;
  assign cs_next = fixed_select_mode ? fixed_select : head.pcs;
  assign cfg_n = cs_config_reg[cs_next];
  assign cfg_a = cs_config_reg[cs_q];
  assign nb_n = spimc_pkg::BITS_BASE + 5'(cfg_n.bits);
  assign nb_a = spimc_pkg::BITS_BASE + 5'(cfg_a.bits);
  assign data_edges = {nb_a, 1'b0};
  assign leading = !edge_q[0];
  assign pop = head_valid && idle_st && en_q && master_select_bit &&
               !dummy_q;

  spimc_fifo #(
    .WIDTH(spimc_pkg::WORD_W),
    .DEPTH(spimc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(ref_clk),
    .rst_n(reset_n),
    .flush(flush),
    .in_valid(tx_valid),
    .in_data(tx_data_reg),
    .in_ready(tx_ready),
    .out_valid(head_valid),
    .out_data(head),
    .out_ready(pop)
  );

  // ----------------------------------------------------------------------
  // extra clock pulse conditions
  // ----------------------------------------------------------------------
  always_comb begin
    all_one = 1'b1;
    for (int i = 0; i < spimc_pkg::NCS; i++) begin
      if (cs_config_reg[i].clock_divider_field != spimc_pkg::DIV_ONE) begin
        all_one = 1'b0;
      end
    end
  end

  always_comb begin
    extra = 1'b0;
    if (cfg_n.clock_polarity && !cfg_n.phase_capture_first &&
        cfg_n.clock_divider_field[0] &&
        cfg_n.clock_divider_field != spimc_pkg::DIV_ONE) begin
      extra = 1'b1;
    end
    if (cfg_n.clock_divider_field == spimc_pkg::DIV_ONE && nb_n[0]) begin
      extra = 1'b1;
    end
    if (cfg_n.clock_polarity && !cfg_n.phase_capture_first &&
        cfg_n.clock_divider_field == spimc_pkg::DIV_ONE &&
        !prev_one_q && !all_one) begin
      extra = 1'b1;
    end
  end

  // held select left idle long enough skips the select delay
  assign direct = cfg_a.cs_hold_after_transfer &&
                  idle_q > 9'(cfg_a.between_transfer_delay) +
                  9'(between_cs_delay);

  // ----------------------------------------------------------------------
  // master engine
  // ----------------------------------------------------------------------
  always_comb begin
    change = cfg_a.phase_capture_first ? !leading :
             (leading && edge_q != spimc_pkg::EDGE_RST);
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= spimc_pkg::ST_IDLE;
      cs_q <= '0;
      cs_on_q <= 1'b0;
      cnt_q <= spimc_pkg::CNT_RST;
      edge_q <= spimc_pkg::EDGE_RST;
      edges_q <= spimc_pkg::EDGE_RST;
      sh_q <= '0;
      rxs_q <= '0;
      last_q <= 1'b0;
      idle_q <= '0;
      prev_one_q <= 1'b1;
      sck_q <= 1'b0;
      mosi_q <= 1'b0;
      m_done_q <= 1'b0;
      suppress_q <= 1'b0;
    end else if (cmd_soft_reset) begin
      state_q <= spimc_pkg::ST_IDLE;
      cs_on_q <= 1'b0;
      m_done_q <= 1'b0;
      suppress_q <= 1'b0;
    end else begin
      m_done_q <= 1'b0;
      case (state_q)
        spimc_pkg::ST_IDLE, spimc_pkg::ST_HOLD: begin
          if (idle_q != spimc_pkg::IDLE_MAX) begin
            idle_q <= idle_q + 1'b1;
          end
          // clock rests at the selected polarity, even before a transfer
          sck_q <= cfg_n.clock_polarity;
          if (pop) begin
            sh_q <= head.data;
            mosi_q <= head.data[4'(nb_n - 5'h1)];
            last_q <= head.last_transfer_bit;
            edges_q <= {nb_n, 1'b0} + (extra ? spimc_pkg::EDGE_EXTRA :
                                       spimc_pkg::EDGE_RST);
            edge_q <= spimc_pkg::EDGE_RST;
            cnt_q <= spimc_pkg::CNT_RST;
            suppress_q <= cs_on_q && cs_q == cs_next &&
                          cfg_n.cs_hold_after_transfer &&
                          cfg_n.clock_divider_field == spimc_pkg::DIV_ONE &&
                          idle_q != '0;
            cs_q <= cs_next;
            if (cs_on_q && (cs_q == cs_next || direct)) begin
              state_q <= spimc_pkg::ST_XFER;
            end else begin
              cs_on_q <= 1'b0;
              cnt_q <= between_cs_delay;
              state_q <= spimc_pkg::ST_CSDLY;
            end
          end
        end
        spimc_pkg::ST_CSDLY: begin
          if (cnt_q == spimc_pkg::CNT_RST) begin
            cs_on_q <= 1'b1;
            state_q <= spimc_pkg::ST_XFER;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        spimc_pkg::ST_XFER: begin
          if (cnt_q + 1'b1 >= cfg_a.clock_divider_field) begin
            cnt_q <= spimc_pkg::CNT_RST;
            sck_q <= !sck_q;
            edge_q <= edge_q + 1'b1;
            // edges past the data edges toggle the clock only
            if (edge_q < data_edges) begin
              if (leading == cfg_a.phase_capture_first) begin
                rxs_q <= {rxs_q[14:0], miso_in};
              end
              if (change) begin
                sh_q <= {sh_q[14:0], 1'b0};
                mosi_q <= sh_q[4'(nb_a - 5'h2)];
              end
            end
            if (edge_q + 1'b1 == edges_q) begin
              cnt_q <= cfg_a.between_transfer_delay;
              state_q <= spimc_pkg::ST_BCT;
            end
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        spimc_pkg::ST_BCT: begin
          if (cnt_q == spimc_pkg::CNT_RST) begin
            m_done_q <= 1'b1;
            prev_one_q <= cfg_a.clock_divider_field == spimc_pkg::DIV_ONE;
            idle_q <= '0;
            if (dummy_q) begin
              sh_q <= '0;
              mosi_q <= 1'b0;
              edge_q <= spimc_pkg::EDGE_RST;
              state_q <= spimc_pkg::ST_XFER;
            end else if (last_q || !cfg_a.cs_hold_after_transfer) begin
              cs_on_q <= 1'b0;
              state_q <= spimc_pkg::ST_IDLE;
            end else begin
              state_q <= spimc_pkg::ST_HOLD;
            end
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        default: begin
          state_q <= spimc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // commands and enable state
  // ----------------------------------------------------------------------
  // soft reset leaves the enable bit alone; only a real off-to-on enable
  // arms the flags, so software must disable first
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      en_q <= 1'b0;
      flags_ok_q <= 1'b0;
      dummy_q <= 1'b0;
    end else if (cmd_soft_reset) begin
      flags_ok_q <= 1'b0;
      dummy_q <= 1'b0;
    end else if (cmd_disable && master_select_bit) begin
      en_q <= 1'b0;
      flags_ok_q <= 1'b0;
      if (!idle_st) begin
        dummy_q <= 1'b1;
      end
    end else if (cmd_enable && !en_q) begin
      en_q <= 1'b1;
      flags_ok_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // slave receiver, mode 0, count from select 0
  // ----------------------------------------------------------------------
  logic sclk_prev_q;
  logic [4:0] s_cnt_q;
  logic [15:0] s_sh_q;
  logic s_done_q;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sclk_prev_q <= 1'b0;
      s_cnt_q <= '0;
      s_sh_q <= '0;
      s_done_q <= 1'b0;
    end else begin
      sclk_prev_q <= slave_clock_in;
      s_done_q <= 1'b0;
      if (cmd_soft_reset || slave_select_n_in || master_select_bit ||
          !en_q) begin
        s_cnt_q <= '0;
      end else if (slave_clock_in && !sclk_prev_q) begin
        s_sh_q <= {s_sh_q[14:0], slave_data_in};
        if (s_cnt_q + 1'b1 == spimc_pkg::BITS_BASE +
            5'(cs_config_reg[0].bits)) begin
          s_cnt_q <= '0;
          s_done_q <= 1'b1;
        end else begin
          s_cnt_q <= s_cnt_q + 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_valid <= 1'b0;
      rx_data <= '0;
      tx_ready_flag <= 1'b0;
      transmit_empty_flag <= 1'b0;
      dma_size_half <= 1'b0;
      serial_clock_out <= 1'b0;
      serial_clock_oe <= 1'b0;
      mosi_out <= 1'b0;
      peripheral_cs_lines_n <= spimc_pkg::CS_OFF;
      enable_state_bit <= 1'b0;
    end else begin
      rx_valid <= m_done_q || s_done_q;
      if (m_done_q) begin
        rx_data <= rxs_q;
      end else if (s_done_q) begin
        rx_data <= s_sh_q;
      end
      tx_ready_flag <= flags_ok_q && tx_ready && !suppress_q;
      transmit_empty_flag <= flags_ok_q && !head_valid && idle_st &&
                             !dummy_q;
      dma_size_half <= fixed_select_mode ? cs_config_reg[0].bits != 4'h0 :
                       cfg_n.bits != 4'h0;
      serial_clock_out <= sck_q;
      serial_clock_oe <= master_select_bit;
      mosi_out <= mosi_q;
      peripheral_cs_lines_n <= cs_on_q ? ~(4'h1 << cs_q) :
                               spimc_pkg::CS_OFF;
      enable_state_bit <= en_q;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  slave_disable_a: assert property (
    en_q && cmd_disable && !master_select_bit && !cmd_soft_reset |=> en_q)
    else $error("disable acted in slave mode");
  dummy_loop_a: assert property (
    dummy_q && !cmd_soft_reset |=> dummy_q)
    else $error("dummy transfers stopped without reset");
  dummy_start_a: assert property (
    cmd_disable && master_select_bit && !idle_st && !cmd_soft_reset
    |=> dummy_q && !en_q)
    else $error("disable during transfer missed dummy mode");
  swrst_keep_a: assert property (
    cmd_soft_reset |=> $stable(en_q) && !flags_ok_q)
    else $error("soft reset changed enable bit");
  reenable_flags_a: assert property (
    en_q && !flags_ok_q && cmd_enable && !cmd_disable |=> ##1
    !transmit_empty_flag && !tx_ready_flag)
    else $error("re-enable set flags");
  dma_size_a: assert property (
    fixed_select_mode
    |=> dma_size_half == ($past(cs_config_reg[0].bits) != 4'h0))
    else $error("dma size not from select 0");
  cs_delay_a: assert property (
    pop && cs_on_q && cs_q != cs_next && !direct && !cmd_soft_reset
    |=> state_q == spimc_pkg::ST_CSDLY && !cs_on_q)
    else $error("select changed without delay");
  direct_switch_a: assert property (
    pop && cs_on_q && cs_q != cs_next && direct && !cmd_soft_reset
    |=> state_q == spimc_pkg::ST_XFER && cs_on_q)
    else $error("held idle switch inserted delay");
  last_release_a: assert property (
    state_q == spimc_pkg::ST_BCT && cnt_q == spimc_pkg::CNT_RST &&
    last_q && !dummy_q && !cmd_soft_reset |=> ##1
    peripheral_cs_lines_n == spimc_pkg::CS_OFF)
    else $error("last transfer kept select low");
  odd_pulse_a: assert property (
    pop && cfg_n.clock_divider_field == spimc_pkg::DIV_ONE && nb_n[0] &&
    !cmd_soft_reset |=> edges_q == {nb_a, 1'b0} + spimc_pkg::EDGE_EXTRA)
    else $error("odd count at divider 1 lacks extra pulse");
  idle_clock_a: assert property (
    idle_st && !cmd_soft_reset |=> sck_q == $past(cfg_n.clock_polarity))
    else $error("idle clock not at polarity");

  xfer_c: cover property (m_done_q && !dummy_q);
  hold_c: cover property (state_q == spimc_pkg::ST_HOLD ##1 pop);
  dummy_c: cover property (dummy_q && m_done_q);
  slave_c: cover property (s_done_q);
endmodule

// [core/spimc_pkg.sv]
// shared constants, types and states of the serial peripheral controller
package spimc_pkg;
  // ----------------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------------
  localparam int NCS = 4;
  localparam int DATA_W = 16;
  localparam int FIFO_DEPTH = 8;
  localparam int WORD_W = 19;
  // ----------------------------------------------------------------------
  // field values and reset values
  // ----------------------------------------------------------------------
  localparam logic [4:0] BITS_BASE = 5'h8;
  localparam logic [7:0] DIV_ONE = 8'h1;
  localparam logic [8:0] IDLE_MAX = 9'h1ff;
  localparam logic [3:0] CS_OFF = 4'hf;
  localparam logic [7:0] CNT_RST = 8'h0;
  localparam logic [5:0] EDGE_RST = 6'h0;
  localparam logic [5:0] EDGE_EXTRA = 6'h2;
  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic clock_polarity;
    logic phase_capture_first;
    logic cs_hold_after_transfer;
    logic [3:0] bits;
    logic [7:0] clock_divider_field;
    logic [7:0] between_transfer_delay;
  } spimc_cs_cfg_s;
  typedef struct packed {
    logic last_transfer_bit;
    logic [1:0] pcs;
    logic [DATA_W-1:0] data;
  } spimc_tx_word_s;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_CSDLY = 5'h02,
    ST_XFER = 5'h04,
    ST_BCT = 5'h08,
    ST_HOLD = 5'h10
  } spimc_state_e;
endpackage

// [verification/spimc_slave_model.sv]
// slave device model on the serial pins, counting clock edges per select
`timescale 1ns/1ps
module spimc_slave_model (
  // clock
  input wire logic clk,
  // serial pins
  input wire logic sclk,
  input wire logic mosi,
  input wire logic [3:0] cs_n,
  output logic miso,
  // observation
  output logic [15:0] rx_word,
  output logic [7:0] edges
);
  logic sclk_q;
  logic sel_q;
  logic float_q;
  wire logic sel = (cs_n != 4'hf);
  // selected, the output answers at once as a slave's driver does;
  // released, it toggles so a late sample never sees a held value
  assign miso = sel ? 1'b1 : float_q;
  initial begin
    edges = 8'h00;
    rx_word = 16'h0000;
    sclk_q = 1'b0;
    sel_q = 1'b0;
    float_q = 1'b0;
  end
  always @(posedge clk) begin
    sclk_q <= sclk;
    sel_q <= sel;
    if (sel && !sel_q) begin
      edges <= 8'h00;
      rx_word <= 16'h0000;
    end else if (sel && sclk != sclk_q) begin
      edges <= edges + 8'h01;
      if (sclk) begin
        rx_word <= {rx_word[14:0], mosi};
      end
    end
    float_q <= ~float_q;
  end
endmodule

// [verification/testbench.sv]
// self-checking bench of the serial peripheral controller
`timescale 1ns/1ps
module testbench;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic cmd_enable = 1'b0;
  logic cmd_disable = 1'b0;
  logic cmd_soft_reset = 1'b0;
  logic master_select_bit = 1'b1;
  logic fixed_select_mode = 1'b0;
  logic [1:0] fixed_select = 2'h0;
  logic [7:0] between_cs_delay = 8'h02;
  spimc_pkg::spimc_cs_cfg_s [spimc_pkg::NCS-1:0] cfg = '0;
  logic tx_valid = 1'b0;
  spimc_pkg::spimc_tx_word_s tx_word = '0;
  logic tx_ready, rx_valid, en_bit, rdy_flag, empty_flag, dma_half;
  logic sclk, sclk_oe, mosi, miso;
  logic [15:0] rx_data, slv_word;
  logic [7:0] slv_edges;
  logic [3:0] cs_n;
  int n_mismatch = 0;
  int samples_checked = 0;
  always #4 ref_clk = ~ref_clk;
  spimc_ctrl i_dut (
    .ref_clk(ref_clk), .reset_n(reset_n),
    .cmd_enable(cmd_enable), .cmd_disable(cmd_disable),
    .cmd_soft_reset(cmd_soft_reset),
    .master_select_bit(master_select_bit),
    .fixed_select_mode(fixed_select_mode), .fixed_select(fixed_select),
    .between_cs_delay(between_cs_delay), .cs_config_reg(cfg),
    .tx_valid(tx_valid), .tx_data_reg(tx_word), .tx_ready(tx_ready),
    .rx_valid(rx_valid), .rx_data(rx_data),
    .enable_state_bit(en_bit), .tx_ready_flag(rdy_flag),
    .transmit_empty_flag(empty_flag), .dma_size_half(dma_half),
    .serial_clock_out(sclk), .serial_clock_oe(sclk_oe),
    .mosi_out(mosi), .miso_in(miso), .peripheral_cs_lines_n(cs_n),
    .slave_clock_in(1'b0), .slave_select_n_in(1'b1),
    .slave_data_in(1'b0)
  );
  spimc_slave_model i_slave (
    .clk(ref_clk), .sclk(sclk), .mosi(mosi), .cs_n(cs_n), .miso(miso),
    .rx_word(slv_word), .edges(slv_edges)
  );
  task final_report;
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task cmd(input logic [2:0] w);
    @(posedge ref_clk);
    {cmd_enable, cmd_disable, cmd_soft_reset} <= w;
    @(posedge ref_clk);
    {cmd_enable, cmd_disable, cmd_soft_reset} <= 3'h0;
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  // offers one word until n of them have been taken
  task push(input logic [15:0] d, input int n);
    int got;
    got = 0;
    @(posedge ref_clk);
    tx_word <= '{1'b1, 2'h0, d};
    tx_valid <= 1'b1;
    for (int i = 0; i < 40 && got < n; i++) begin
      @(negedge ref_clk);
      if (tx_ready === 1'b1) got++;
      @(posedge ref_clk);
    end
    tx_valid <= 1'b0;
    if (got < n) begin
      n_mismatch++;
      final_report();
    end
  endtask
  task xfer(input logic [3:0] bits, input logic [7:0] div,
            input logic pol, input logic ph, input logic [7:0] exp_edges);
    int i;
    @(posedge ref_clk);
    cfg[0] <= '{pol, ph, 1'b0, bits, div, 8'h01};
    repeat (3) @(posedge ref_clk);
    push(16'h00a5, 1);
    for (i = 0; i < 3000 && rx_valid !== 1'b1; i++) @(negedge ref_clk);
    if (i == 3000) begin
      n_mismatch++;
      final_report();
    end
    if (bits == 4'h0 && ph) begin
      chk(rx_data, 16'h00ff);
    end
    repeat (8) @(negedge ref_clk);
    chk(slv_edges, exp_edges);
    if (bits == 4'h0 && ph) begin
      chk(slv_word & 16'h00ff, 16'h00a5);
    end
    chk(cs_n, spimc_pkg::CS_OFF);
  endtask
  // waits past the current cycle for the next received word
  task wait_rx;
    int i;
    @(negedge ref_clk);
    for (i = 0; i < 3000 && rx_valid !== 1'b1; i++) @(negedge ref_clk);
    if (i == 3000) begin
      n_mismatch++;
      final_report();
    end
  endtask
  task fifo_fill;
    push(16'h1234, 8);
    @(negedge ref_clk);
    chk(tx_ready, 1'b0);
    cmd(3'h1);
    chk(tx_ready, 1'b1);
  endtask
  task dma_size;
    @(posedge ref_clk);
    fixed_select_mode <= 1'b1;
    fixed_select <= 2'h1;
    cfg[0].bits <= 4'h2;
    cfg[1].bits <= 4'h0;
    repeat (4) @(negedge ref_clk);
    chk(dma_half, 1'b1);
    @(posedge ref_clk);
    cfg[0].bits <= 4'h0;
    repeat (4) @(negedge ref_clk);
    chk(dma_half, 1'b0);
    @(posedge ref_clk);
    fixed_select_mode <= 1'b0;
  endtask
  task reset_keeps_enable;
    @(posedge ref_clk);
    master_select_bit <= 1'b0;
    cmd(3'h2);
    chk(en_bit, 1'b1);
    chk(sclk_oe, 1'b0);
    @(posedge ref_clk);
    master_select_bit <= 1'b1;
    cmd(3'h1);
    chk(en_bit, 1'b1);
    cmd(3'h4);
    chk(empty_flag, 1'b0);
    chk(rdy_flag, 1'b0);
    cmd(3'h2);
    chk(en_bit, 1'b0);
    cmd(3'h4);
    chk(empty_flag, 1'b1);
    chk(rdy_flag, 1'b1);
  endtask
  // disable in mid-transfer: dummy words run on under a held select
  task dummy_run;
    push(16'h0001, 1);
    repeat (6) @(posedge ref_clk);
    cmd(3'h2);
    wait_rx();
    wait_rx();
    chk(cs_n, 4'he);
    chk(en_bit, 1'b0);
    cmd(3'h1);
    chk(cs_n, spimc_pkg::CS_OFF);
  endtask
  initial begin
    // master select stands before any chip-select configuration
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    fifo_fill();
    dma_size();
    cmd(3'h2);
    cmd(3'h4);
    chk(en_bit, 1'b1);
    xfer(4'h0, 8'h02, 1'b0, 1'b1, 8'd16);
    xfer(4'h1, 8'h01, 1'b0, 1'b1, 8'd20);
    xfer(4'h2, 8'h01, 1'b0, 1'b1, 8'd20);
    xfer(4'h0, 8'h03, 1'b1, 1'b0, 8'd18);
    xfer(4'h0, 8'h02, 1'b1, 1'b0, 8'd16);
    reset_keeps_enable();
    dummy_run();
    final_report();
  end
endmodule
